// ===== src/code_lock_pkg.sv
// constants for the code memory lock and scrambling block
// assumes a single 125 MHz core clock and synchronous reset
package code_lock_pkg;
    // ----------------------------------------------------------------
    // image layout and field positions
    // ----------------------------------------------------------------
    localparam int KEY_DEPTH = 64;
    localparam int KEY_AW = 6;
    localparam logic [15:0] IMG8_CODE_LAST = 16'h1fff;
    localparam logic [15:0] IMG8_KEY_BASE = 16'h2000;
    localparam logic [15:0] IMG8_LOCK_ADDR = 16'h2040;
    localparam logic [15:0] IMG16_CODE_LAST = 16'h3fff;
    localparam logic [15:0] IMG16_KEY_BASE = 16'h4000;
    localparam logic [15:0] IMG16_LOCK_ADDR = 16'h4040;
    localparam int IMG_LOCK_FIRST_BIT = 0;
    localparam int IMG_LOCK_SECOND_BIT = 1;
    localparam logic [7:0] KEY_BLANK = 8'hff;
    localparam logic [7:0] READ_BLOCKED = 8'hff;
    localparam logic [2:0] LOCK_RESET = 3'h0;
    // lock levels (cumulative), gray along the usual path
    typedef enum logic [1:0]
    {
        LVL_NONE = 2'b00,
        LVL_FIRST = 2'b01,
        LVL_SECOND = 2'b11,
        LVL_ALL = 2'b10
    } level_type;
endpackage

// ===== src/key_store.sv
// 64-byte key memory, registered read port
// assumes the owner gates writes; reset fills all ones
`timescale 1ns/1ps
`default_nettype none
module key_store
#(
    parameter int DEPTH = code_lock_pkg::KEY_DEPTH,
    parameter int AW = code_lock_pkg::KEY_AW
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data,
    output logic programmed
);
    typedef struct packed
    {
        logic [DEPTH-1:0][7:0] mem;
        logic [7:0] rd;
        logic prog;
    } state_type;
    state_type q_ff;
    state_type nxt_q;

    // write, any-byte-programmed tracking, registered read
    always_comb
    begin
        nxt_q = q_ff;
        if (wr_en)
        begin
            nxt_q.mem[wr_addr] = wr_data;
            if (wr_data != code_lock_pkg::KEY_BLANK)
                nxt_q.prog = 1'b1;
        end
        nxt_q.rd = q_ff.mem[rd_addr];
    end

    // reset leaves every key bit at one
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q_ff.mem <= {DEPTH{code_lock_pkg::KEY_BLANK}}; // [RULE12]
            q_ff.rd <= code_lock_pkg::KEY_BLANK;
            q_ff.prog <= 1'b0;
        end
        else
            q_ff <= nxt_q;
    end

    assign rd_data = q_ff.rd;
    assign programmed = q_ff.prog;
endmodule
`default_nettype wire

// ===== src/code_memory_security_lock.sv
// code memory lock, key scrambling and access gating
// assumes programmer strobes are one-cycle, synchronous to SYS_CLK
//
// Operation
// (RULE1) no locks: no protection, verify still scrambled
// (RULE2) first lock: block external table reads internal
// (RULE3) first lock: latch access pin at reset
// (RULE4) first lock: refuse code, key programming
// (RULE5) second lock adds verify readout block
// (RULE6) third lock blocks all external execution
// (RULE7) non-cumulative lock combinations are undefined
// (RULE8) rom variant: two locks, second needs first
// (RULE9) 8k image code, key, lock byte
// (RULE10) 16k image code, key, lock byte
// (RULE11) image byte: zero enables; key ff blank
// (RULE12) key array resets to all ones
// (RULE13) rom second lock inhibits verify readout
// (RULE14) verify data is xnor code with key
// (RULE15) no readout path for key contents
// (RULE16) key byte chosen by address low six
// (RULE17) lock, key loaded before reset release
`timescale 1ns/1ps
`default_nettype none
module code_memory_security_lock
#(
    parameter bit MASK_ROM = 1'b0,
    parameter bit IMAGE_16K = 1'b0
)
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic EXTERNAL_ACCESS_SELECT,
    input wire logic FETCH_FROM_EXTERNAL,
    input wire logic CODE_TABLE_READ_INSTR,
    input wire logic [15:0] FETCH_ADDR,
    input wire logic FETCH_ADDR_INTERNAL,
    input wire logic [7:0] CODE_RD_DATA,
    output logic [7:0] TABLE_READ_DATA,
    output logic EXTERNAL_FETCH_ALLOWED,
    output logic EXT_ACCESS_EFFECTIVE,
    input wire logic IMG_LOAD_VALID,
    input wire logic [15:0] IMG_LOAD_ADDR,
    input wire logic [7:0] IMG_LOAD_DATA,
    input wire logic PGM_CODE_REQ,
    input wire logic PGM_KEY_REQ,
    input wire logic [5:0] PGM_KEY_ADDR,
    input wire logic [7:0] PGM_KEY_DATA,
    input wire logic PGM_LOCK_FIRST_REQ,
    input wire logic PGM_LOCK_SECOND_REQ,
    input wire logic PGM_LOCK_THIRD_REQ,
    output logic CODE_WRITE_ENABLE,
    input wire logic VERIFY_REQ,
    input wire logic [15:0] VERIFY_ADDR,
    input wire logic [7:0] VERIFY_CODE_DATA,
    output logic [7:0] VERIFY_DATA,
    output logic VERIFY_VALID,
    output logic VERIFY_BLOCKED,
    output logic [1:0] LOCK_LEVEL,
    output logic LOCK_UNDEFINED
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic lock_bit_first;
        logic lock_bit_second;
        logic lock_bit_third;
        logic ea_latched;
        logic in_reset;
        logic [7:0] table_data;
        logic [7:0] verify_data;
        logic verify_valid;
        logic verify_blocked;
        logic verify_pend;
        logic [5:0] verify_key_addr;
        logic [7:0] verify_code;
    } state_type;
    state_type s_ff;
    state_type nxt_s;

    logic [7:0] key_byte;
    logic key_programmed;
    logic key_clear;
    logic key_wr_en;
    logic [5:0] key_wr_addr;
    logic [7:0] key_wr_data;
    logic img_in_key;
    logic img_is_lock;
    code_lock_pkg::level_type level;

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    // cumulative level decode of the three lock bits
    function automatic code_lock_pkg::level_type lvl_of(
        input logic b1,
        input logic b2,
        input logic b3
    );
        code_lock_pkg::level_type r;
        r = code_lock_pkg::LVL_NONE;
        if (b1 && b2 && b3)
            r = code_lock_pkg::LVL_ALL;
        else if (b1 && b2)
            r = code_lock_pkg::LVL_SECOND;
        else if (b1)
            r = code_lock_pkg::LVL_FIRST;
        return r;
    endfunction

    // address falls in [base, base + 63]
    function automatic logic in_key_window(
        input logic [15:0] a,
        input logic [15:0] base
    );
        return a[15:6] == base[15:6];
    endfunction

    // ----------------------------------------------------------------
    // image decode and key store
    // ----------------------------------------------------------------
    // key and lock byte positions depend on image size
    always_comb
    begin
        if (IMAGE_16K)
        begin
            img_in_key = in_key_window(IMG_LOAD_ADDR,
                code_lock_pkg::IMG16_KEY_BASE); // [RULE10]
            img_is_lock = IMG_LOAD_ADDR == code_lock_pkg::IMG16_LOCK_ADDR;
        end
        else
        begin
            img_in_key = in_key_window(IMG_LOAD_ADDR,
                code_lock_pkg::IMG8_KEY_BASE); // [RULE9]
            img_is_lock = IMG_LOAD_ADDR == code_lock_pkg::IMG8_LOCK_ADDR;
        end
    end

    // key writes: image load only during reset, programmer when unlocked
    always_comb
    begin
        key_wr_en = 1'b0;
        key_wr_addr = PGM_KEY_ADDR;
        key_wr_data = PGM_KEY_DATA;
        if (MASK_ROM && s_ff.in_reset && IMG_LOAD_VALID && img_in_key)
        begin
            key_wr_en = 1'b1; // [RULE17]
            key_wr_addr = IMG_LOAD_ADDR[5:0];
            key_wr_data = IMG_LOAD_DATA;
        end
        else if (!MASK_ROM && PGM_KEY_REQ && !s_ff.lock_bit_first)
            key_wr_en = 1'b1; // [RULE4]
    end

    // clear the key only in reset cycles without an image byte, so key
    // bytes loaded during reset survive; loader keeps valid up throughout
    assign key_clear = RESET &&
        !(MASK_ROM && s_ff.in_reset && IMG_LOAD_VALID); // [RULE17]

    // read port only feeds the scrambler, never an output as is
    key_store u_key
    (
        .clk(SYS_CLK),
        .rst(key_clear),
        .wr_en(key_wr_en),
        .wr_addr(key_wr_addr),
        .wr_data(key_wr_data),
        .rd_addr(VERIFY_ADDR[5:0]), // [RULE16]
        .rd_data(key_byte),
        .programmed(key_programmed)
    );

    assign level = lvl_of(s_ff.lock_bit_first, s_ff.lock_bit_second,
        s_ff.lock_bit_third);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.in_reset = RESET;
        // lock bits are one-way: once set only reset of image clears
        if (PGM_LOCK_FIRST_REQ)
            nxt_s.lock_bit_first = 1'b1;
        // rom parts never take the second lock without the first
        if (PGM_LOCK_SECOND_REQ && (!MASK_ROM || s_ff.lock_bit_first))
            nxt_s.lock_bit_second = 1'b1; // [RULE8]
        if (PGM_LOCK_THIRD_REQ && !MASK_ROM)
            nxt_s.lock_bit_third = 1'b1; // [RULE8]
        if (MASK_ROM && s_ff.in_reset && IMG_LOAD_VALID && img_is_lock)
        begin
            // zero in the image byte enables the lock
            nxt_s.lock_bit_first =
                !IMG_LOAD_DATA[code_lock_pkg::IMG_LOCK_FIRST_BIT]; // [RULE11]
            nxt_s.lock_bit_second =
                !IMG_LOAD_DATA[code_lock_pkg::IMG_LOCK_FIRST_BIT] &&
                !IMG_LOAD_DATA[code_lock_pkg::IMG_LOCK_SECOND_BIT]; // [RULE8]
        end
        // access pin follows freely unless first lock latches it
        if (s_ff.in_reset || !s_ff.lock_bit_first)
            nxt_s.ea_latched = EXTERNAL_ACCESS_SELECT; // [RULE3]
        // table read data, blocked for external code reading internal
        if (CODE_TABLE_READ_INSTR && FETCH_FROM_EXTERNAL &&
            FETCH_ADDR_INTERNAL && s_ff.lock_bit_first)
            nxt_s.table_data = code_lock_pkg::READ_BLOCKED; // [RULE2]
        else if (CODE_TABLE_READ_INSTR)
            nxt_s.table_data = CODE_RD_DATA;
        // verify: capture, then scramble with key byte one cycle later
        nxt_s.verify_valid = 1'b0;
        nxt_s.verify_pend = VERIFY_REQ;
        nxt_s.verify_code = VERIFY_CODE_DATA;
        nxt_s.verify_key_addr = VERIFY_ADDR[5:0];
        if (s_ff.verify_pend)
        begin
            nxt_s.verify_valid = 1'b1;
            if (level == code_lock_pkg::LVL_SECOND ||
                level == code_lock_pkg::LVL_ALL)
            begin
                nxt_s.verify_blocked = 1'b1; // [RULE5] [RULE13]
                nxt_s.verify_data = code_lock_pkg::READ_BLOCKED;
            end
            else
            begin
                nxt_s.verify_blocked = 1'b0; // [RULE1]
                if (key_programmed)
                    nxt_s.verify_data =
                        ~(s_ff.verify_code ^ key_byte); // [RULE14]
                else
                    nxt_s.verify_data = s_ff.verify_code;
            end
        end
    end

    // lock bits hold through reset; mask parts reload first, second from the image byte and clear third
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            s_ff.in_reset <= 1'b1;
            s_ff.table_data <= 8'h00;
            s_ff.verify_data <= 8'h00;
            s_ff.verify_valid <= 1'b0;
            s_ff.verify_blocked <= 1'b0;
            s_ff.verify_pend <= 1'b0;
            s_ff.verify_key_addr <= 6'h00;
            s_ff.verify_code <= 8'h00;
            s_ff.ea_latched <= nxt_s.ea_latched;
            if (MASK_ROM)
            begin
                s_ff.lock_bit_first <= nxt_s.lock_bit_first; // [RULE17]
                s_ff.lock_bit_second <= nxt_s.lock_bit_second;
                s_ff.lock_bit_third <= 1'b0;
            end
            else
            begin
                s_ff.lock_bit_first <= s_ff.lock_bit_first;
                s_ff.lock_bit_second <= s_ff.lock_bit_second;
                s_ff.lock_bit_third <= s_ff.lock_bit_third;
            end
        end
        else
            s_ff <= nxt_s;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // undefined combinations reported; fetch gating needs all three bits, verify block the first two
    assign LOCK_UNDEFINED = (s_ff.lock_bit_second && !s_ff.lock_bit_first)
        || (s_ff.lock_bit_third && !s_ff.lock_bit_second); // [RULE7]
    assign LOCK_LEVEL = level;
    assign EXTERNAL_FETCH_ALLOWED = !(s_ff.lock_bit_first &&
        s_ff.lock_bit_second && s_ff.lock_bit_third); // [RULE6]
    assign EXT_ACCESS_EFFECTIVE = s_ff.ea_latched;
    assign CODE_WRITE_ENABLE = PGM_CODE_REQ && !MASK_ROM &&
        !s_ff.lock_bit_first; // [RULE4]
    assign TABLE_READ_DATA = s_ff.table_data;
    assign VERIFY_DATA = s_ff.verify_data; // [RULE15]
    assign VERIFY_VALID = s_ff.verify_valid;
    assign VERIFY_BLOCKED = s_ff.verify_blocked;
endmodule
`default_nettype wire

// ===== dv/code_lock_chk.sv
// port checker for the code memory lock block
// assumes bind onto the top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module code_lock_chk
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic FETCH_FROM_EXTERNAL,
    input wire logic CODE_TABLE_READ_INSTR,
    input wire logic FETCH_ADDR_INTERNAL,
    input wire logic [7:0] CODE_RD_DATA,
    input wire logic [7:0] TABLE_READ_DATA,
    input wire logic EXTERNAL_FETCH_ALLOWED,
    input wire logic EXT_ACCESS_EFFECTIVE,
    input wire logic PGM_CODE_REQ,
    input wire logic CODE_WRITE_ENABLE,
    input wire logic VERIFY_REQ,
    input wire logic [7:0] VERIFY_DATA,
    input wire logic VERIFY_VALID,
    input wire logic VERIFY_BLOCKED,
    input wire logic [1:0] LOCK_LEVEL
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);
    a_fetch_gate: assert property (
        EXTERNAL_FETCH_ALLOWED == (LOCK_LEVEL != 2'h2))
        else $error("external fetch gate wrong");
    a_code_refuse: assert property (
        CODE_WRITE_ENABLE |-> PGM_CODE_REQ && LOCK_LEVEL == 2'h0)
        else $error("code write while locked");
    a_verify_time: assert property (
        VERIFY_VALID |-> $past(VERIFY_REQ, 2))
        else $error("verify answer without request");
    a_verify_shut: assert property (
        VERIFY_VALID && LOCK_LEVEL[1] |->
        VERIFY_BLOCKED && VERIFY_DATA == 8'hff)
        else $error("verify readout not blocked");
    a_verify_open: assert property (
        VERIFY_VALID && LOCK_LEVEL == 2'h0 |-> !VERIFY_BLOCKED)
        else $error("verify blocked without locks");
    a_table_shut: assert property (
        CODE_TABLE_READ_INSTR && FETCH_FROM_EXTERNAL &&
        FETCH_ADDR_INTERNAL && LOCK_LEVEL != 2'h0 |=>
        TABLE_READ_DATA == 8'hff)
        else $error("external table read leaked");
    a_table_pass: assert property (
        CODE_TABLE_READ_INSTR && LOCK_LEVEL == 2'h0 |=>
        TABLE_READ_DATA == $past(CODE_RD_DATA))
        else $error("table read data wrong");
    a_pin_latch: assert property (
        LOCK_LEVEL != 2'h0 && !$past(RESET) && !$past(RESET, 2) |->
        $stable(EXT_ACCESS_EFFECTIVE))
        else $error("access pin not held");
    c_verify_shut: cover property (VERIFY_VALID && VERIFY_BLOCKED);
    c_verify_open: cover property (VERIFY_VALID && !VERIFY_BLOCKED);
    c_table_shut: cover property (CODE_TABLE_READ_INSTR &&
        FETCH_FROM_EXTERNAL && LOCK_LEVEL != 2'h0);
endmodule
bind code_memory_security_lock code_lock_chk chk
(
    .SYS_CLK(SYS_CLK),
    .RESET(RESET),
    .FETCH_FROM_EXTERNAL(FETCH_FROM_EXTERNAL),
    .CODE_TABLE_READ_INSTR(CODE_TABLE_READ_INSTR),
    .FETCH_ADDR_INTERNAL(FETCH_ADDR_INTERNAL),
    .CODE_RD_DATA(CODE_RD_DATA),
    .TABLE_READ_DATA(TABLE_READ_DATA),
    .EXTERNAL_FETCH_ALLOWED(EXTERNAL_FETCH_ALLOWED),
    .EXT_ACCESS_EFFECTIVE(EXT_ACCESS_EFFECTIVE),
    .PGM_CODE_REQ(PGM_CODE_REQ),
    .CODE_WRITE_ENABLE(CODE_WRITE_ENABLE),
    .VERIFY_REQ(VERIFY_REQ),
    .VERIFY_DATA(VERIFY_DATA),
    .VERIFY_VALID(VERIFY_VALID),
    .VERIFY_BLOCKED(VERIFY_BLOCKED),
    .LOCK_LEVEL(LOCK_LEVEL)
);
`default_nettype wire

// ===== dv/code_store_model.sv
// far side model: internal code bytes for fetch and verify
// assumes an 8k image, answers in the same cycle
`timescale 1ns/1ps
`default_nettype none
module code_store_model
(
    input wire logic [15:0] fetch_addr,
    input wire logic [15:0] verify_addr,
    output logic [7:0] fetch_data,
    output logic [7:0] verify_data
);
    // code occupies 0000h..1fffh, upper bits unused
    assign fetch_data = fetch_addr[7:0] ^ {3'h0, fetch_addr[12:8]} ^
        8'h3c;
    assign verify_data = verify_addr[7:0] ^ {3'h0, verify_addr[12:8]} ^
        8'h3c;
endmodule
`default_nettype wire

// ===== dv/test_code_memory_security_lock.sv
// bench for the lock block, mask rom builds, 8k and 16k image
// assumes image loads during reset and one 8 ns clock
`timescale 1ns/1ps
`default_nettype none
module test_code_memory_security_lock;
    logic sys_clk = 1'b0, reset = 1'b1, ea_pin = 1'b1, from_ext = 1'b0;
    logic tbl_rd = 1'b0, img_v = 1'b0, pgm_code = 1'b0, pgm_key = 1'b0;
    logic pgm_l2 = 1'b0, pgm_l3 = 1'b0, ver_req = 1'b0;
    logic [15:0] f_addr = 16'h0, img_a = 16'h0, ver_a = 16'h0;
    logic [7:0] img_d = 8'h0, code_rd, ver_code, tbl_data, ver_data;
    logic ext_ok, ea_eff, code_we, ver_v, ver_blk;
    logic [1:0] lvl;
    logic pgm_l1 = 1'b0, f_int = 1'b1, undef;
    logic [5:0] k_addr = 6'h00;
    logic [7:0] k_data = 8'h00, ver16;
    logic [1:0] lvl16;
    int num_errors = 0, num_checks = 0, cycles = 0, i;
    logic [15:0] addrs [4] = '{16'h0000, 16'h003f, 16'h0040, 16'h1fff};
    code_memory_security_lock #(.MASK_ROM(1'b1), .IMAGE_16K(1'b0)) dut
    (
        .SYS_CLK(sys_clk), .RESET(reset), .EXTERNAL_ACCESS_SELECT(ea_pin),
        .FETCH_FROM_EXTERNAL(from_ext), .CODE_TABLE_READ_INSTR(tbl_rd),
        .FETCH_ADDR(f_addr), .FETCH_ADDR_INTERNAL(f_int),
        .CODE_RD_DATA(code_rd), .TABLE_READ_DATA(tbl_data),
        .EXTERNAL_FETCH_ALLOWED(ext_ok), .EXT_ACCESS_EFFECTIVE(ea_eff),
        .IMG_LOAD_VALID(img_v), .IMG_LOAD_ADDR(img_a), .IMG_LOAD_DATA(img_d),
        .PGM_CODE_REQ(pgm_code), .PGM_KEY_REQ(pgm_key),
        .PGM_KEY_ADDR(k_addr), .PGM_KEY_DATA(k_data),
        .PGM_LOCK_FIRST_REQ(pgm_l1), .PGM_LOCK_SECOND_REQ(pgm_l2),
        .PGM_LOCK_THIRD_REQ(pgm_l3), .CODE_WRITE_ENABLE(code_we),
        .VERIFY_REQ(ver_req), .VERIFY_ADDR(ver_a),
        .VERIFY_CODE_DATA(ver_code), .VERIFY_DATA(ver_data),
        .VERIFY_VALID(ver_v), .VERIFY_BLOCKED(ver_blk),
        .LOCK_LEVEL(lvl), .LOCK_UNDEFINED(undef)
    );
    // second build with the 16k image layout, same stimulus
    code_memory_security_lock #(.MASK_ROM(1'b1), .IMAGE_16K(1'b1)) dut16
    (
        .SYS_CLK(sys_clk), .RESET(reset), .EXTERNAL_ACCESS_SELECT(ea_pin),
        .FETCH_FROM_EXTERNAL(from_ext), .CODE_TABLE_READ_INSTR(tbl_rd),
        .FETCH_ADDR(f_addr), .FETCH_ADDR_INTERNAL(f_int),
        .CODE_RD_DATA(code_rd), .TABLE_READ_DATA(),
        .EXTERNAL_FETCH_ALLOWED(), .EXT_ACCESS_EFFECTIVE(),
        .IMG_LOAD_VALID(img_v), .IMG_LOAD_ADDR(img_a), .IMG_LOAD_DATA(img_d),
        .PGM_CODE_REQ(pgm_code), .PGM_KEY_REQ(pgm_key),
        .PGM_KEY_ADDR(k_addr), .PGM_KEY_DATA(k_data),
        .PGM_LOCK_FIRST_REQ(pgm_l1), .PGM_LOCK_SECOND_REQ(pgm_l2),
        .PGM_LOCK_THIRD_REQ(pgm_l3), .CODE_WRITE_ENABLE(),
        .VERIFY_REQ(ver_req), .VERIFY_ADDR(ver_a),
        .VERIFY_CODE_DATA(ver_code), .VERIFY_DATA(ver16),
        .VERIFY_VALID(), .VERIFY_BLOCKED(),
        .LOCK_LEVEL(lvl16), .LOCK_UNDEFINED()
    );
    code_store_model far_side
    (
        .fetch_addr(f_addr), .verify_addr(ver_a),
        .fetch_data(code_rd), .verify_data(ver_code)
    );
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] code_of(input logic [15:0] a);
        return a[7:0] ^ {3'h0, a[12:8]} ^ 8'h3c;
    endfunction
    function automatic logic [7:0] key_of(input logic [5:0] k);
        return {k, 2'h1} ^ 8'h80;
    endfunction
    function automatic logic [7:0] scr(input logic [15:0] a);
        return ~(code_of(a) ^ key_of(a[5:0]));
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // reset with an image: lock byte, then optional key
    task automatic boot(input logic [7:0] lock_b, input bit key_on);
        reset <= 1'b1;
        repeat (5) @(posedge sys_clk);
        img_v <= 1'b1;
        img_a <= code_lock_pkg::IMG8_LOCK_ADDR;
        img_d <= lock_b;
        @(posedge sys_clk);
        img_a <= code_lock_pkg::IMG16_LOCK_ADDR;
        for (i = 0; i < 128 && key_on; i++)
        begin
            @(posedge sys_clk);
            img_a <= (i < 64 ? code_lock_pkg::IMG8_KEY_BASE :
                code_lock_pkg::IMG16_KEY_BASE) + 16'(i % 64);
            img_d <= key_of(6'(i));
        end
        @(posedge sys_clk);
        img_v <= 1'b0;
        reset <= 1'b0;
    endtask
    // answer stands in the second cycle after the request is driven
    task automatic verify(input logic [15:0] a, input logic [7:0] e,
        input logic b);
        @(posedge sys_clk);
        ver_req <= 1'b1;
        ver_a <= a;
        @(posedge sys_clk);
        ver_req <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(ver_data, e);
        chk(ver16, e);
        chk({7'h0, ver_v}, 8'h01);
        chk({7'h0, ver_blk}, {7'h0, b});
    endtask
    task automatic tread(input logic ext, input logic [15:0] a,
        input logic [7:0] e);
        @(posedge sys_clk);
        tbl_rd <= 1'b1;
        from_ext <= ext;
        f_addr <= a;
        @(posedge sys_clk);
        tbl_rd <= 1'b0;
        #1;
        chk(tbl_data, e);
    endtask
    // ------------------------------------------------------------
    // clock, watchdog, scenarios
    // ------------------------------------------------------------
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            wrap_up();
        end
    end
    initial
    begin
        boot(8'hff, 1'b0);
        verify(16'h0123, code_of(16'h0123), 1'b0);
        tread(1'b1, 16'h0456, code_of(16'h0456));
        chk({4'h0, lvl16, lvl}, 8'h00);
        @(posedge sys_clk);
        ea_pin <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({7'h0, ea_eff}, 8'h00);
        ea_pin <= 1'b1;
        pgm_l2 <= 1'b1;
        @(posedge sys_clk);
        pgm_l2 <= 1'b0;
        #1;
        chk({5'h0, undef, lvl}, 8'h00);
        boot(8'hff, 1'b1);
        for (i = 0; i < 4; i++)
            verify(addrs[i], scr(addrs[i]), 1'b0);
        boot(8'hfe, 1'b1);
        chk({4'h0, lvl16, lvl}, 8'h05);
        tread(1'b1, 16'h0456, 8'hff);
        tread(1'b0, 16'h0456, code_of(16'h0456));
        f_int <= 1'b0;
        tread(1'b1, 16'h0456, code_of(16'h0456));
        f_int <= 1'b1;
        ea_pin <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk({7'h0, ea_eff}, 8'h01);
        @(posedge sys_clk);
        pgm_code <= 1'b1;
        pgm_key <= 1'b1;
        k_addr <= 6'h05;
        k_data <= 8'h5a;
        #1;
        chk({7'h0, code_we}, 8'h00);
        @(posedge sys_clk);
        pgm_code <= 1'b0;
        pgm_key <= 1'b0;
        verify(16'h0005, scr(16'h0005), 1'b0);
        @(posedge sys_clk);
        pgm_l1 <= 1'b1;
        pgm_l2 <= 1'b1;
        @(posedge sys_clk);
        pgm_l1 <= 1'b0;
        pgm_l2 <= 1'b0;
        verify(16'h0005, 8'hff, 1'b1);
        pgm_l3 <= 1'b1;
        @(posedge sys_clk);
        pgm_l3 <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({4'h0, undef, ext_ok, lvl}, 8'h07);
        boot(8'hfc, 1'b0);
        verify(16'h0321, 8'hff, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
